// >>> logic/scmcfg_pkg.sv
// Constants shared by the chip-select mode configuration bank
package scmcfg_pkg;
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int NUM_REGIONS = 4;
    // Register byte offsets, one aligned word per region
    localparam logic [11:0] REGION0_MODE_CONFIG_OFS = 12'h000;
    localparam logic [11:0] REGION1_MODE_CONFIG_OFS = 12'h004;
    localparam logic [11:0] REGION2_MODE_CONFIG_OFS = 12'h008;
    localparam logic [11:0] REGION3_MODE_CONFIG_OFS = 12'h00c;
    // Field positions
    localparam int START_MSB = 31;
    localparam int START_LSB = 24;
    localparam int FILL_MSB = 23;
    localparam int FILL_LSB = 16;
    localparam int LATCH_BIT = 11;
    localparam int BURST_MSB = 5;
    localparam int BURST_LSB = 3;
    localparam int WIDTH_MSB = 1;
    localparam int WIDTH_LSB = 0;
    // Fixed start-address bytes per region
    localparam logic [7:0] START_BYTE [NUM_REGIONS] =
        '{8'h60, 8'h61, 8'h62, 8'h63};
    // Field values
    localparam logic [7:0] FILL_VALUE = 8'hff;
    localparam logic LATCH_RESET = 1'b1;
    localparam logic [2:0] BURST_SINGLE = 3'h0;
    localparam logic [2:0] BURST_FOUR = 3'h1;
    localparam logic [2:0] BURST_RESET = 3'h0;
    localparam logic [1:0] WIDTH_16BIT = 2'h1;
    localparam logic [1:0] WIDTH_RESET = 2'h1;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : scmcfg_pkg

// >>> logic/scmcfg_cfg_if.sv
// Carrier for one region's configuration fields and readback word
interface scmcfg_cfg_if;
    logic [31:0] word;
    logic latch_used;
    logic [2:0] burst;
    logic [1:0] width;
    modport src (output word, output latch_used, output burst,
        output width);
    modport dst (input word, input latch_used, input burst, input width);
endinterface : scmcfg_cfg_if

// >>> logic/scmcfg_region.sv
// One region's read-only mode configuration register
module scmcfg_region #(
    parameter logic [7:0] START = 8'h60
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Configuration fields out
    scmcfg_cfg_if.src cfg
);
    logic latch_r;
    logic latch_nxt;
    logic [2:0] burst_r;
    logic [2:0] burst_nxt;
    logic [1:0] width_r;
    logic [1:0] width_nxt;

    // No write path: fields hold their reset values
    always_comb
    begin
        latch_nxt = latch_r; // see [R6]
        burst_nxt = burst_r;
        width_nxt = width_r;
    end

    // Field storage with documented reset values
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            latch_r <= scmcfg_pkg::LATCH_RESET; // see [R2]
            burst_r <= scmcfg_pkg::BURST_RESET; // see [R3]
            width_r <= scmcfg_pkg::WIDTH_RESET; // see [R4]
        end
        else
        begin
            latch_r <= latch_nxt;
            burst_r <= burst_nxt;
            width_r <= width_nxt;
        end
    end

    // Readback word; undefined bits read as zero
    always_comb
    begin
        cfg.word = 32'h0000_0000;
        cfg.word[scmcfg_pkg::START_MSB:scmcfg_pkg::START_LSB] = START;
        cfg.word[scmcfg_pkg::FILL_MSB:scmcfg_pkg::FILL_LSB] =
            scmcfg_pkg::FILL_VALUE; // see [R6]
        cfg.word[scmcfg_pkg::LATCH_BIT] = latch_r; // see [R2]
        cfg.word[scmcfg_pkg::BURST_MSB:scmcfg_pkg::BURST_LSB] = burst_r;
        cfg.word[scmcfg_pkg::WIDTH_MSB:scmcfg_pkg::WIDTH_LSB] = width_r;
    end

    // Field outputs
    assign cfg.latch_used = latch_r;
    assign cfg.burst = burst_r;
    assign cfg.width = width_r;
endmodule : scmcfg_region

// >>> logic/scmcfg_bank.sv
// Chip-select mode configuration bank with an AXI4-Lite slave
// Function
// [R1] Bits 31:24 read region start byte: 0x60, 0x61, 0x62.
// [R2] Bit 11 reports address-latch strobe use; resets to 1.
// [R3] Bits 5:3 read burst length: 000 single, 001 four beats; reset 000.
// [R4] Bits 1:0 bus width: 01 means 16 bits; reset 01.
// [R5] Region three register has the same layout, start byte 0x63.
// [R6] All fields read-only; writes ignored; bits 23:16 read all ones.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
module scmcfg_bank #(
    parameter int ADDR_W = scmcfg_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // Write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address channel
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // Read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Per-region configuration outputs
    output logic [scmcfg_pkg::NUM_REGIONS-1:0] latch_strobe_used,
    output logic [2:0] read_burst_len [scmcfg_pkg::NUM_REGIONS],
    output logic [1:0] bus_width_sel [scmcfg_pkg::NUM_REGIONS]
);
    localparam int NR = scmcfg_pkg::NUM_REGIONS;

    logic [31:0] word [NR];

    // One register per region, each with its own start byte
    for (genvar g = 0; g < NR; g++)
    begin : g_region
        scmcfg_cfg_if cfg_if ();
        scmcfg_region #(
            .START(scmcfg_pkg::START_BYTE[g]) // see [R1] [R5]
        ) u_region (
            .aclk(aclk),
            .aresetn(aresetn),
            .cfg(cfg_if.src)
        );
        assign word[g] = cfg_if.word;
        assign latch_strobe_used[g] = cfg_if.latch_used;
        assign read_burst_len[g] = cfg_if.burst;
        assign bus_width_sel[g] = cfg_if.width;
    end

    // Register select decoded from a byte address
    typedef struct packed {
        logic hit;
        logic [1:0] idx;
    } scmcfg_sel_s;

    // Match an address against the four register offsets
    // Bits 1:0 do not select; any other address is a miss
    function automatic scmcfg_sel_s decode(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] wa;
        scmcfg_sel_s sel;
        wa = {a[ADDR_W-1:2], 2'b00};
        sel.hit = 1'b1;
        sel.idx = 2'h0;
        case (wa)
            ADDR_W'(scmcfg_pkg::REGION0_MODE_CONFIG_OFS):
                sel.idx = 2'h0;
            ADDR_W'(scmcfg_pkg::REGION1_MODE_CONFIG_OFS):
                sel.idx = 2'h1;
            ADDR_W'(scmcfg_pkg::REGION2_MODE_CONFIG_OFS):
                sel.idx = 2'h2;
            ADDR_W'(scmcfg_pkg::REGION3_MODE_CONFIG_OFS): // see [R5]
                sel.idx = 2'h3;
            default:
                sel.hit = 1'b0;
        endcase
        decode = sel;
    endfunction : decode

    // Write channel state
    logic aw_held_r;
    logic aw_held_nxt;
    logic w_held_r;
    logic w_held_nxt;
    logic [ADDR_W-1:0] waddr_r;
    logic [ADDR_W-1:0] waddr_nxt;
    logic awready_r;
    logic awready_nxt;
    logic wready_r;
    logic wready_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;

    // Take address and data in either order, answer once both are in
    always_comb
    begin
        scmcfg_sel_s wsel;
        // Address held, or the one being taken at this edge
        waddr_nxt = (awvalid & awready_r) ? awaddr : waddr_r;
        wsel = decode(waddr_nxt);
        aw_held_nxt = aw_held_r | (awvalid & awready_r);
        w_held_nxt = w_held_r | (wvalid & wready_r);
        bvalid_nxt = bvalid_r & ~bready;
        bresp_nxt = bresp_r;
        if (aw_held_nxt && w_held_nxt && !bvalid_r)
        begin
            // Data is dropped: the bank has no writable field
            bvalid_nxt = 1'b1; // see [R6]
            bresp_nxt = wsel.hit ? scmcfg_pkg::RESP_OKAY
                : scmcfg_pkg::RESP_SLVERR;
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
        end
        awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
        wready_nxt = ~w_held_nxt & ~bvalid_nxt;
    end

    // Write channel registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            waddr_r <= '0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= scmcfg_pkg::RESP_OKAY;
        end
        else
        begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            waddr_r <= waddr_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // Read channel state
    logic arready_r;
    logic arready_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;

    // Answer a read one cycle after the address is taken
    always_comb
    begin
        scmcfg_sel_s rsel;
        rsel = decode(araddr);
        rvalid_nxt = rvalid_r & ~rready;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (arvalid && arready_r)
        begin
            rvalid_nxt = 1'b1;
            // A miss reads zero with an error response
            if (rsel.hit)
            begin
                rdata_nxt = word[rsel.idx]; // see [R1] [R5]
                rresp_nxt = scmcfg_pkg::RESP_OKAY;
            end
            else
            begin
                rdata_nxt = 32'h0000_0000;
                rresp_nxt = scmcfg_pkg::RESP_SLVERR;
            end
        end
        arready_nxt = ~rvalid_nxt;
    end

    // Read channel registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= scmcfg_pkg::RESP_OKAY;
        end
        else
        begin
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
endmodule : scmcfg_bank

// >>> tb/scmcfg_mem_model.sv
// Memory-side model of the region configuration
module scmcfg_mem_model (
    // Configuration in
    input wire logic [3:0] latch_used,
    input wire logic [2:0] burst [4],
    input wire logic [1:0] width [4],
    // What the memory sees
    output logic [2:0] beats [4],
    output logic [3:0] wide16
);
    timeunit 1ns;
    timeprecision 1ps;
    // Decode codes per region
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            beats[i] = (burst[i] == 3'h1) ? 3'h4 : 3'h1;
            wide16[i] = width[i] == 2'h1 && latch_used[i];
        end
    end
endmodule : scmcfg_mem_model

// >>> tb/scmcfg_bank_properties.sv
// Port checks for the configuration bank
module scmcfg_bank_properties (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write side
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    // Read side
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    // Configuration
    input wire logic [3:0] latch_strobe_used,
    input wire logic [2:0] read_burst_len [4],
    input wire logic [1:0] bus_width_sel [4]
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Good read answer
    wire ok = rvalid && rresp == 2'h0;
    // Fields of every good read
    start_byte_a: assert property (
        ok |-> rdata[31:26] == 6'h18)
        else $error("start byte");
    latch_bit_a: assert property (
        ok |-> rdata[11] && latch_strobe_used == 4'hf)
        else $error("latch bit");
    burst_code_a: assert property (
        ok |-> rdata[5:3] == 3'h0 && read_burst_len[3] == 3'h0)
        else $error("burst");
    bus_width_a: assert property (
        ok |-> rdata[1:0] == 2'h1 && bus_width_sel[0] == 2'h1)
        else $error("width");
    fill_bits_a: assert property (
        ok |-> rdata[23:16] == 8'hff)
        else $error("fill");
    // Handshake timing
    write_resp_a: assert property (
        awvalid && awready && wvalid && wready |=> bvalid)
        else $error("no bvalid");
    resp_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("bresp moved");
    read_hold_a: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("rdata moved");
    cover property (ok);
    cover property (bvalid && bresp == 2'h2);
    cover property (rvalid && !rready);
endmodule : scmcfg_bank_properties

// >>> tb/tb_scmcfg_bank.sv
// Testbench for the configuration bank
module tb_scmcfg_bank;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
        fail_count++; $display("mismatch %s %h %h", n, e, g); end end
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [3:0] wstrb, latch_strobe_used, wide16;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [2:0] read_burst_len [4];
    logic [2:0] beats [4];
    logic [1:0] bus_width_sel [4];
    int fail_count, checks_done, cycles;
    scmcfg_bank scmcfg_bank_inst (.aclk, .aresetn, .awaddr, .awprot,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .latch_strobe_used, .read_burst_len,
        .bus_width_sel);
    scmcfg_mem_model scmcfg_mem_model_inst (.latch_used(latch_strobe_used),
        .burst(read_burst_len), .width(bus_width_sel), .beats(beats),
        .wide16(wide16));
    // Closing verdict
    task automatic report_and_stop;
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // Bus write, slow holds bready back
    task automatic wr(input logic [11:0] a, input logic s,
        output logic [1:0] r);
        logic aw = 1'b1;
        logic w = 1'b1;
        @(posedge aclk);
        // Data would flip latch, burst and width if it ever landed
        {awaddr, wdata, wstrb} <= {a, 32'h0000_000a, 4'hf};
        {awvalid, wvalid, bready} <= {2'h3, !s};
        while (aw || w)
        begin
            @(posedge aclk);
            aw = aw && !awready;
            w = w && !wready;
            awvalid <= aw;
            wvalid <= w;
        end
        while (!bvalid) @(posedge aclk);
        if (s)
        begin
            bready <= 1'b1;
            @(posedge aclk);
        end
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    // Bus read, slow holds rready back
    task automatic rd(input logic [11:0] a, input logic s,
        output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 1'b1, !s};
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        if (s)
        begin
            rready <= 1'b1;
            @(posedge aclk);
        end
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask : rd
    // All four region words
    task automatic read_regions;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 4; i++)
        begin
            rd(12'(i * 4), i[0], d, r);
            `CHK("rresp", 2'h0, r)
            `CHK("start", 8'h60 + 8'(i), d[31:24])
            `CHK("fill", 8'hff, d[23:16])
            `CHK("latch", 1'b1, d[11])
            `CHK("burst", 3'h0, d[5:3])
            `CHK("width", 2'h1, d[1:0])
        end
    endtask : read_regions
    // Writes leave every field alone
    task automatic write_ignored;
        logic [1:0] r;
        for (int i = 0; i < 4; i++)
        begin
            wr(12'(i * 4), i[0], r);
            `CHK("bresp", 2'h0, r)
            `CHK("beats", 3'h1, beats[i])
        end
        `CHK("wide", 4'hf, wide16)
        read_regions();
    endtask : write_ignored
    // Unmapped offsets are refused
    task automatic unmapped;
        logic [31:0] d;
        logic [1:0] r;
        wr(12'h010, 1'b0, r);
        `CHK("bresp", 2'h2, r)
        rd(12'hffc, 1'b1, d, r);
        `CHK("rresp", 2'h2, r)
        `CHK("rdata", 32'h0, d)
    endtask : unmapped
    // Configuration outputs show their reset values while reset is low
    task automatic reset_state;
        `CHK("latch", 4'hf, latch_strobe_used)
        `CHK("beats", 3'h1, beats[3])
        `CHK("wide", 4'hf, wide16)
    endtask : reset_state
    // Clock
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Hang guard
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    // Main sequence, with a second reset in mid-run
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, awprot, arprot, wstrb, wdata} = '0;
        repeat (6) @(posedge aclk);
        reset_state();
        aresetn <= 1'b1;
        read_regions();
        write_ignored();
        unmapped();
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        reset_state();
        aresetn <= 1'b1;
        read_regions();
        report_and_stop();
    end
endmodule : tb_scmcfg_bank
bind scmcfg_bank scmcfg_bank_properties scmcfg_bank_properties_inst (
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp,
    .bvalid, .bready, .rdata, .rresp, .rvalid, .rready,
    .latch_strobe_used, .read_burst_len, .bus_width_sel);
